// ---- hdl/dsc_strap_cfg.sv ----
// top: strap sampling, option registers, power-down and output drive control
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
module dsc_strap_cfg
   import dsc_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // power and link status
   input wire logic POWER_DOWN_N,
   input wire logic LOCK_IN,
   input wire logic BIST_PASS_IN,
   // received parallel data and recovered clock level
   input wire logic [23:0] RX_DATA,
   input wire logic [2:0] RX_CTRL,
   input wire logic RX_PCLK,
   // shared data pins
   input wire logic [23:0] DO_IN,
   output logic [23:0] DO_OUT,
   output logic [23:0] DO_OE,
   // control and clock outputs
   output logic [2:0] CO_OUT,
   output logic CO_OE,
   output logic PIXEL_CLK_OUT,
   output logic PIXEL_CLK_OE,
   output logic LOCK_OUT,
   // pass pin, doubles as hold-low strap
   input wire logic PASS_IN,
   output logic PASS_OUT,
   output logic PASS_OE,
   // option outputs to the analog blocks
   output logic FILTER_EN,
   output logic COMPAT_A,
   output logic COMPAT_B,
   output logic SSC_LOW_BAND,
   output logic [3:0] SPREAD_RANGE,
   output logic CLK_FAST_SLEW,
   output logic DATA_FAST_SLEW,
   output logic STROBE_RISING,
   output logic [3:0] EQ_LEVEL,
   output logic [2:0] OSC_SEL,
   output logic [1:0] MAP_SEL,
   // register port
   input wire logic [REG_AW-1:0] REG_ADDR,
   input wire logic [REG_DW-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [REG_DW-1:0] REG_RDATA
);

   // sleep select high drives low, low leaves pins released
   function automatic logic sleep_oe(input logic sel);
      return sel;
   endfunction

   dsc_strap_if st(); // link to the sampler

   // ---------------- power sequencing ----------------
   dsc_state_e state_r; // sequencing state
   dsc_state_e state_nxt;
   logic [2:0] settle_r; // settle counter
   logic [2:0] settle_nxt;
   logic latched_r; // straps captured at least once
   logic latched_nxt;
   logic sample; // capture request

   // state transitions
   always_comb begin
      state_nxt = state_r;
      settle_nxt = settle_r;
      latched_nxt = latched_r;
      sample = 1'b0;
      case (state_r)
         ST_OFF: begin
            settle_nxt = 3'h0;
            if (POWER_DOWN_N) begin
               state_nxt = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            // pins stay inputs while straps settle
            if (!POWER_DOWN_N) begin
               state_nxt = ST_OFF;
            end else if (settle_r == 3'(SETTLE_CYC - 1)) begin
               sample = 1'b1;
               latched_nxt = 1'b1;
               state_nxt = ST_RUN;
            end else begin
               settle_nxt = settle_r + 3'h1;
            end
         end
         ST_RUN: begin
            if (!POWER_DOWN_N) begin
               state_nxt = ST_OFF;
            end
         end
         default: begin
            state_nxt = ST_OFF;
         end
      endcase
   end

   // registers
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         state_r <= ST_OFF;
         settle_r <= 3'h0;
         latched_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         settle_r <= settle_nxt;
         latched_r <= latched_nxt;
      end
   end

   assign st.pins = DO_IN;
   assign st.op_pin = PASS_IN;
   assign st.sample = sample;

   // strap capture
   dsc_strap_sampler u_sampler (
      .clk(CLK),
      .resetn(RESETN),
      .st(st)
   );

   // ---------------- option registers ----------------
   dsc_cfg_s cfg_r; // working options
   dsc_cfg_s cfg_nxt;
   logic release_r; // hold-low released by software
   logic release_nxt;
   // read data go straight into the port flop, so they stand one cycle after the strobe
   logic [REG_DW-1:0] rdata_nxt;
   logic holding; // outputs held low

   assign holding = cfg_r.hold_outputs_low & ~release_r;

   // strap load, software override and readback
   always_comb begin
      cfg_nxt = cfg_r;
      release_nxt = release_r;
      rdata_nxt = '0;
      if (st.loaded) begin
         cfg_nxt = st.cfg;
         release_nxt = 1'b0;
      end
      // a write after the capture overrides the pin value
      if (REG_WR) begin
         case (REG_ADDR)
            REG_CFG0: begin
               cfg_nxt.mode = REG_WDATA[CFG0_MODE_LSB +: 2];
               cfg_nxt.ssc_low_band_sel = REG_WDATA[CFG0_LOW_BAND];
               cfg_nxt.clk_out_fast_slew = REG_WDATA[CFG0_CLK_SLEW];
               cfg_nxt.data_out_fast_slew = REG_WDATA[CFG0_DATA_SLEW];
               cfg_nxt.hold_outputs_low = REG_WDATA[CFG0_HOLD_LOW];
               cfg_nxt.sleep_output_state_sel = REG_WDATA[CFG0_SLEEP_SEL];
               cfg_nxt.strobe_edge_sel = REG_WDATA[CFG0_STROBE];
            end
            REG_CFG1: begin
               cfg_nxt.rx_equalizer_level = REG_WDATA[CFG1_EQ_LSB +: 4];
               cfg_nxt.osc_freq_sel = REG_WDATA[CFG1_OSC_LSB +: 3];
            end
            REG_CFG2: begin
               cfg_nxt.spread_range_sel = REG_WDATA[CFG2_SPREAD_LSB +: 4];
               cfg_nxt.map_sel = REG_WDATA[CFG2_MAP_LSB +: 2];
            end
            REG_CTRL: begin
               if (REG_WDATA[CTRL_RELEASE]) begin
                  release_nxt = 1'b1;
               end
            end
            default: begin
               // unmapped writes are dropped
            end
         endcase
      end
      if (REG_RD) begin
         case (REG_ADDR)
            REG_CFG0: begin
               rdata_nxt[CFG0_MODE_LSB +: 2] = cfg_r.mode;
               rdata_nxt[CFG0_LOW_BAND] = cfg_r.ssc_low_band_sel;
               rdata_nxt[CFG0_CLK_SLEW] = cfg_r.clk_out_fast_slew;
               rdata_nxt[CFG0_DATA_SLEW] = cfg_r.data_out_fast_slew;
               rdata_nxt[CFG0_HOLD_LOW] = cfg_r.hold_outputs_low;
               rdata_nxt[CFG0_SLEEP_SEL] = cfg_r.sleep_output_state_sel;
               rdata_nxt[CFG0_STROBE] = cfg_r.strobe_edge_sel;
            end
            REG_CFG1: begin
               rdata_nxt[CFG1_EQ_LSB +: 4] = cfg_r.rx_equalizer_level;
               rdata_nxt[CFG1_OSC_LSB +: 3] = cfg_r.osc_freq_sel;
            end
            REG_CFG2: begin
               rdata_nxt[CFG2_SPREAD_LSB +: 4] = cfg_r.spread_range_sel;
               rdata_nxt[CFG2_MAP_LSB +: 2] = cfg_r.map_sel;
            end
            REG_CTRL: begin
               rdata_nxt[CTRL_RELEASE] = release_r;
            end
            REG_STATUS: begin
               rdata_nxt[STAT_POWERED] = (state_r == ST_RUN);
               rdata_nxt[STAT_LOCK] = LOCK_IN;
               rdata_nxt[STAT_HOLDING] = holding;
               rdata_nxt[STAT_LATCHED] = latched_r;
            end
            default: begin
               rdata_nxt = '0; // unmapped reads as zero
            end
         endcase
      end
   end

   // registers; map select resets to 00
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         cfg_r <= '0;
         release_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         release_r <= release_nxt;
      end
   end

   // ---------------- output drive ----------------
   logic pclk_q_r; // previous recovered clock level
   logic launch; // data launch point
   logic [23:0] do_nxt;
   logic [23:0] do_oe_nxt;
   logic [2:0] co_nxt;
   logic co_oe_nxt;
   logic pclk_nxt;
   logic pclk_oe_nxt;
   logic pass_nxt;
   logic pass_oe_nxt;

   // launch opposite the strobe edge so data is stable there
   assign launch = cfg_r.strobe_edge_sel ? (pclk_q_r & ~RX_PCLK)
                                         : (~pclk_q_r & RX_PCLK);

   // output values by power and link state
   always_comb begin
      do_nxt = DO_OUT;
      do_oe_nxt = DO_OE;
      co_nxt = CO_OUT;
      co_oe_nxt = CO_OE;
      pclk_nxt = PIXEL_CLK_OUT;
      pclk_oe_nxt = PIXEL_CLK_OE;
      pass_nxt = PASS_OUT;
      pass_oe_nxt = PASS_OE;
      if (state_r == ST_SETTLE || (state_r == ST_OFF && !latched_r)) begin
         // released: not yet powered up since reset, or pins acting as straps
         do_nxt = '0;
         do_oe_nxt = '0;
         co_nxt = '0;
         co_oe_nxt = 1'b0;
         pclk_nxt = 1'b0;
         pclk_oe_nxt = 1'b0;
         pass_nxt = 1'b0;
         pass_oe_nxt = 1'b0;
      end else if (state_r != ST_RUN || !LOCK_IN) begin
         // power-down or unlocked: sleep select decides
         do_nxt = '0;
         do_oe_nxt = {24{sleep_oe(cfg_r.sleep_output_state_sel)}};
         co_nxt = '0;
         co_oe_nxt = sleep_oe(cfg_r.sleep_output_state_sel);
         pclk_nxt = 1'b0;
         pclk_oe_nxt = sleep_oe(cfg_r.sleep_output_state_sel);
         pass_nxt = 1'b0;
         pass_oe_nxt = sleep_oe(cfg_r.sleep_output_state_sel);
      end else if (holding) begin
         // hold-low owns the pins, sleep select not consulted
         do_nxt = '0;
         do_oe_nxt = '1;
         co_nxt = '0;
         co_oe_nxt = 1'b1;
         pclk_nxt = 1'b0;
         pclk_oe_nxt = 1'b1;
         pass_nxt = 1'b0;
         pass_oe_nxt = 1'b1;
      end else begin
         // locked and free: received data toggles out
         do_oe_nxt = '1;
         co_oe_nxt = 1'b1;
         pclk_oe_nxt = 1'b1;
         pass_oe_nxt = 1'b1;
         pclk_nxt = RX_PCLK;
         pass_nxt = BIST_PASS_IN;
         if (launch) begin
            do_nxt = RX_DATA;
            co_nxt = RX_CTRL;
         end
      end
   end

   // registers
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         pclk_q_r <= 1'b0;
         DO_OUT <= '0;
         DO_OE <= '0;
         CO_OUT <= '0;
         CO_OE <= 1'b0;
         PIXEL_CLK_OUT <= 1'b0;
         PIXEL_CLK_OE <= 1'b0;
         PASS_OUT <= 1'b0;
         PASS_OE <= 1'b0;
      end else begin
         pclk_q_r <= RX_PCLK;
         DO_OUT <= do_nxt;
         DO_OE <= do_oe_nxt;
         CO_OUT <= co_nxt;
         CO_OE <= co_oe_nxt;
         PIXEL_CLK_OUT <= pclk_nxt;
         PIXEL_CLK_OE <= pclk_oe_nxt;
         PASS_OUT <= pass_nxt;
         PASS_OE <= pass_oe_nxt;
      end
   end

   // ---------------- option outputs ----------------
   logic spread_on; // spread clocking active

   assign spread_on = (cfg_r.spread_range_sel != SPREAD_OFF);

   // registered copies of the working options
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         FILTER_EN <= 1'b0;
         COMPAT_A <= 1'b0;
         COMPAT_B <= 1'b0;
         SSC_LOW_BAND <= 1'b0;
         SPREAD_RANGE <= '0;
         CLK_FAST_SLEW <= 1'b0;
         DATA_FAST_SLEW <= 1'b0;
         STROBE_RISING <= 1'b0;
         EQ_LEVEL <= '0;
         OSC_SEL <= '0;
         MAP_SEL <= '0;
         LOCK_OUT <= 1'b0;
         REG_RDATA <= '0;
      end else begin
         FILTER_EN <= (cfg_r.mode == MODE_FILT_ON);
         COMPAT_A <= (cfg_r.mode == MODE_COMPAT_A);
         COMPAT_B <= (cfg_r.mode == MODE_COMPAT_B);
         SSC_LOW_BAND <= spread_on & cfg_r.ssc_low_band_sel;
         SPREAD_RANGE <= cfg_r.spread_range_sel;
         CLK_FAST_SLEW <= cfg_r.clk_out_fast_slew;
         DATA_FAST_SLEW <= cfg_r.data_out_fast_slew;
         STROBE_RISING <= cfg_r.strobe_edge_sel;
         EQ_LEVEL <= cfg_r.rx_equalizer_level;
         OSC_SEL <= cfg_r.osc_freq_sel;
         MAP_SEL <= cfg_r.map_sel;
         LOCK_OUT <= (state_r == ST_RUN) & LOCK_IN;
         REG_RDATA <= rdata_nxt;
      end
   end
endmodule

// ---- hdl/dsc_pkg.sv ----
// package: constants, types and strap decode for the strap configuration block
package dsc_pkg;
   // register bus shape
   localparam int REG_AW = 4;
   localparam int REG_DW = 8;
   // register offsets
   localparam logic [3:0] REG_CFG0 = 4'h0;
   localparam logic [3:0] REG_CFG1 = 4'h1;
   localparam logic [3:0] REG_CFG2 = 4'h2;
   localparam logic [3:0] REG_CTRL = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   // field positions in the configuration registers
   localparam int CFG0_MODE_LSB = 0;
   localparam int CFG0_LOW_BAND = 2;
   localparam int CFG0_CLK_SLEW = 3;
   localparam int CFG0_DATA_SLEW = 4;
   localparam int CFG0_HOLD_LOW = 5;
   localparam int CFG0_SLEEP_SEL = 6;
   localparam int CFG0_STROBE = 7;
   localparam int CFG1_EQ_LSB = 0;
   localparam int CFG1_OSC_LSB = 4;
   localparam int CFG2_SPREAD_LSB = 0;
   localparam int CFG2_MAP_LSB = 4;
   localparam int CTRL_RELEASE = 0;
   // status bit positions
   localparam int STAT_POWERED = 0;
   localparam int STAT_LOCK = 1;
   localparam int STAT_HOLDING = 2;
   localparam int STAT_LATCHED = 3;
   // shared data pins that carry straps
   localparam int PIN_MODE1 = 22;
   localparam int PIN_MODE0 = 23;
   localparam int PIN_LOW_BAND = 20;
   localparam int PIN_CLK_SLEW = 21;
   localparam int PIN_DATA_SLEW = 19;
   localparam int PIN_SLEEP_SEL = 18;
   localparam int PIN_STROBE = 17;
   localparam int PIN_EQ_LSB = 12;
   localparam int PIN_OSC_LSB = 8;
   localparam int PIN_SPREAD_LSB = 3;
   localparam int PIN_MAP1 = 1;
   localparam int PIN_MAP0 = 0;
   // filter configuration codes
   localparam logic [1:0] MODE_FILT_OFF = 2'h0;
   localparam logic [1:0] MODE_FILT_ON = 2'h1;
   localparam logic [1:0] MODE_COMPAT_A = 2'h2;
   localparam logic [1:0] MODE_COMPAT_B = 2'h3;
   // spread range code that leaves spread clocking off
   localparam logic [3:0] SPREAD_OFF = 4'h0;
   // strap settle time before sampling
   localparam int CLK_PERIOD_NS = 50;
   localparam int SETTLE_NS = 100;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // working option set
   typedef struct packed {
      logic [1:0] mode;
      logic ssc_low_band_sel;
      logic clk_out_fast_slew;
      logic data_out_fast_slew;
      logic hold_outputs_low;
      logic sleep_output_state_sel;
      logic strobe_edge_sel;
      logic [3:0] rx_equalizer_level;
      logic [2:0] osc_freq_sel;
      logic [3:0] spread_range_sel;
      logic [1:0] map_sel;
   } dsc_cfg_s;

   // power sequencing states
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_SETTLE = 2'b01,
      ST_RUN = 2'b10
   } dsc_state_e;

   // pin levels to option set
   function automatic dsc_cfg_s strap_decode(input logic [23:0] pins, input logic op_pin);
      dsc_cfg_s c;
      c.mode = {pins[PIN_MODE1], pins[PIN_MODE0]};
      c.ssc_low_band_sel = pins[PIN_LOW_BAND];
      c.clk_out_fast_slew = pins[PIN_CLK_SLEW];
      c.data_out_fast_slew = pins[PIN_DATA_SLEW];
      c.hold_outputs_low = op_pin;
      c.sleep_output_state_sel = pins[PIN_SLEEP_SEL];
      c.strobe_edge_sel = pins[PIN_STROBE];
      c.rx_equalizer_level = pins[PIN_EQ_LSB +: 4];
      c.osc_freq_sel = pins[PIN_OSC_LSB +: 3];
      c.spread_range_sel = pins[PIN_SPREAD_LSB +: 4];
      c.map_sel = {pins[PIN_MAP1], pins[PIN_MAP0]};
      return c;
   endfunction
endpackage

// ---- hdl/dsc_strap_if.sv ----
// interface: strap pins, sample request and latched option set
`timescale 1ns/1ps
interface dsc_strap_if;
   import dsc_pkg::*;
   logic [23:0] pins; // shared data pin levels
   logic op_pin; // level of the pass pin
   logic sample; // one-cycle capture request
   dsc_cfg_s cfg; // latched options
   logic loaded; // one-cycle pulse after capture
   modport sampler(input pins, input op_pin, input sample, output cfg, output loaded);
   modport core(output pins, output op_pin, output sample, input cfg, input loaded);
endinterface

// ---- hdl/dsc_strap_sampler.sv ----
// strap sampler: captures the strap pins once per power-up
`timescale 1ns/1ps
module dsc_strap_sampler
   import dsc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // strap side
   dsc_strap_if.sampler st
);
   dsc_cfg_s cfg_r; // latched options
   dsc_cfg_s cfg_nxt;
   logic loaded_r; // capture pulse
   logic loaded_nxt;

   // capture on request, hold otherwise
   always_comb begin
      cfg_nxt = cfg_r;
      loaded_nxt = 1'b0;
      if (st.sample) begin
         cfg_nxt = strap_decode(st.pins, st.op_pin);
         loaded_nxt = 1'b1;
      end
   end

   // registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cfg_r <= '0;
         loaded_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         loaded_r <= loaded_nxt;
      end
   end

   assign st.cfg = cfg_r;
   assign st.loaded = loaded_r;
endmodule

// ---- tb/dsc_board_model.sv ----
// board model: strap resistors on the shared data pins and the pass pin
`timescale 1ns/1ps
module dsc_board_model (
   // strap levels fitted on the board
   input wire logic [23:0] straps,
   input wire logic hold_strap,
   // device pin drive
   input wire logic [23:0] do_out,
   input wire logic [23:0] do_oe,
   input wire logic pass_out,
   input wire logic pass_oe,
   // resolved pin levels
   output logic [23:0] do_in,
   output logic pass_in
);
   // a released pin settles to its strap resistor level
   always_comb begin
      for (int i = 0; i < 24; i++) begin
         do_in[i] = do_oe[i] ? do_out[i] : straps[i];
      end
      pass_in = pass_oe ? pass_out : hold_strap;
   end
endmodule

// ---- tb/dsc_strap_cfg_props.sv ----
// checker: port timing relations of the strap configuration block
`timescale 1ns/1ps
module dsc_strap_cfg_chk
   import dsc_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // power and link
   input wire logic POWER_DOWN_N,
   input wire logic LOCK_IN,
   // pin drive
   input wire logic [23:0] DO_OUT,
   input wire logic [23:0] DO_OE,
   input wire logic [2:0] CO_OUT,
   input wire logic CO_OE,
   input wire logic PIXEL_CLK_OE,
   input wire logic LOCK_OUT,
   // option outputs
   input wire logic FILTER_EN,
   input wire logic COMPAT_A,
   input wire logic COMPAT_B,
   input wire logic SSC_LOW_BAND,
   input wire logic [3:0] SPREAD_RANGE,
   input wire logic CLK_FAST_SLEW,
   input wire logic DATA_FAST_SLEW,
   input wire logic STROBE_RISING,
   input wire logic [3:0] EQ_LEVEL,
   input wire logic [2:0] OSC_SEL,
   input wire logic [1:0] MAP_SEL,
   // register port
   input wire logic [REG_AW-1:0] REG_ADDR,
   input wire logic [REG_DW-1:0] REG_WDATA,
   input wire logic REG_WR
);
   logic seen_r; // power-down released once since reset
   logic seen_nxt;
   // marker sets on the first release of power-down
   always_comb begin
      seen_nxt = seen_r | POWER_DOWN_N;
   end
   // register the marker
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         seen_r <= 1'b0;
      end else begin
         seen_r <= seen_nxt;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   // write to one place, then a quiet cycle there
   sequence cfg_wr(logic [3:0] a);
      REG_WR && REG_ADDR == a ##1 !(REG_WR && REG_ADDR == a);
   endsequence
   pins_released_a: assert property (!seen_r |-> DO_OE == 24'h0 && !CO_OE && !PIXEL_CLK_OE)
      else $error("outputs driven before first power-up");
   mode_write_a: assert property (cfg_wr(REG_CFG0) |=> {FILTER_EN, COMPAT_A, COMPAT_B} ==
      {$past(REG_WDATA[1:0], 2) == MODE_FILT_ON, $past(REG_WDATA[1:0], 2) == MODE_COMPAT_A,
      $past(REG_WDATA[1:0], 2) == MODE_COMPAT_B}) else $error("filter mode decode wrong");
   slew_write_a: assert property (cfg_wr(REG_CFG0) |=> {CLK_FAST_SLEW, DATA_FAST_SLEW,
      STROBE_RISING} == {$past(REG_WDATA[3], 2), $past(REG_WDATA[4], 2), $past(REG_WDATA[7], 2)})
      else $error("slew or strobe override wrong");
   eq_write_a: assert property (cfg_wr(REG_CFG1) |=> {OSC_SEL, EQ_LEVEL} == $past(REG_WDATA[6:0], 2))
      else $error("equalizer or oscillator override wrong");
   spread_write_a: assert property (cfg_wr(REG_CFG2) |=> {MAP_SEL, SPREAD_RANGE} ==
      $past(REG_WDATA[5:0], 2)) else $error("spread or map override wrong");
   band_ignored_a: assert property (SSC_LOW_BAND |-> SPREAD_RANGE != SPREAD_OFF)
      else $error("low band set with spread off");
   power_down_a: assert property (!POWER_DOWN_N [*3] |-> !LOCK_OUT)
      else $error("lock shown while powered down");
   unlock_quiet_a: assert property (!LOCK_IN [*3] |-> DO_OUT == 24'h0 && CO_OUT == 3'h0)
      else $error("data driven while unlocked");
   lock_follow_a: assert property (LOCK_OUT |-> $past(LOCK_IN))
      else $error("lock output without lock input");
   map_default_a: assert property ($rose(RESETN) |-> MAP_SEL == 2'h0)
      else $error("map select not 00 after reset");
endmodule
bind dsc_strap_cfg dsc_strap_cfg_chk i_dsc_strap_cfg_chk (.*);

// ---- tb/dsc_strap_cfg_test.sv ----
// testbench: strap sampling, overrides, power-down and output control
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module dsc_strap_cfg_test;
   import dsc_pkg::*;
   // design ports
   logic CLK, RESETN, POWER_DOWN_N, LOCK_IN, BIST_PASS_IN, RX_PCLK, CO_OE;
   logic [23:0] RX_DATA, DO_IN, DO_OUT, DO_OE;
   logic [2:0] RX_CTRL, CO_OUT, OSC_SEL;
   logic PIXEL_CLK_OUT, PIXEL_CLK_OE, LOCK_OUT, PASS_IN, PASS_OUT, PASS_OE;
   logic FILTER_EN, COMPAT_A, COMPAT_B, SSC_LOW_BAND, CLK_FAST_SLEW, DATA_FAST_SLEW;
   logic STROBE_RISING, REG_WR, REG_RD;
   logic [3:0] SPREAD_RANGE, EQ_LEVEL;
   logic [1:0] MAP_SEL;
   logic [REG_AW-1:0] REG_ADDR;
   logic [REG_DW-1:0] REG_WDATA, REG_RDATA, rd_v;
   // board straps, expectations, counters
   logic [23:0] straps, s;
   logic [23:0] pat [4] = '{24'h5a3c96, 24'ha5c369, 24'h0f1e2d, 24'hf0e1d2};
   logic [26:0] xp;
   logic hold_strap;
   int n_mismatch, cmp_count;

   dsc_strap_cfg i_dsc_strap_cfg (.*);
   dsc_board_model i_dsc_board_model (.straps(straps), .hold_strap(hold_strap),
      .do_out(DO_OUT), .do_oe(DO_OE), .pass_out(PASS_OUT), .pass_oe(PASS_OE),
      .do_in(DO_IN), .pass_in(PASS_IN));

   // 20 MHz clock
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   // wait n rising edges
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
   endtask
   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask
   // one-cycle read strobe, data taken when it has settled
   task automatic rd(input logic [3:0] a);
      @(posedge CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK);
      REG_RD <= 1'b0;
      @(negedge CLK);
      rd_v = REG_RDATA;
   endtask
   // move the power-down pin, then let sequencing finish
   task automatic pwr(input logic v);
      @(posedge CLK);
      POWER_DOWN_N <= v;
      cyc(8);
   endtask
   // move the recovered clock level
   task automatic pk(input logic v);
      @(posedge CLK);
      RX_PCLK <= v;
      cyc(4);
   endtask
   // option outputs against a strap vector
   task automatic chk_opts(input logic [23:0] p);
      logic [1:0] m;
      m = {p[PIN_MODE1], p[PIN_MODE0]};
      `CHK(FILTER_EN, m == MODE_FILT_ON)
      `CHK({COMPAT_A, COMPAT_B}, {m == MODE_COMPAT_A, m == MODE_COMPAT_B})
      `CHK(SSC_LOW_BAND, p[PIN_LOW_BAND] && p[PIN_SPREAD_LSB +: 4] != SPREAD_OFF)
      `CHK({CLK_FAST_SLEW, DATA_FAST_SLEW}, {p[PIN_CLK_SLEW], p[PIN_DATA_SLEW]})
      `CHK(STROBE_RISING, p[PIN_STROBE])
      `CHK({EQ_LEVEL, OSC_SEL}, {p[PIN_EQ_LSB +: 4], p[PIN_OSC_LSB +: 3]})
      `CHK({SPREAD_RANGE, MAP_SEL}, {p[PIN_SPREAD_LSB +: 4], p[PIN_MAP1], p[PIN_MAP0]})
   endtask
   // verdict and end of run
   task automatic complete_run();
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // watchdog, far beyond the couple of hundred cycles of the tests
   initial begin
      #1_000_000;
      n_mismatch++;
      complete_run();
   end

   initial begin
      RESETN = 1'b0;
      POWER_DOWN_N = 1'b0;
      LOCK_IN = 1'b0;
      BIST_PASS_IN = 1'b1;
      RX_PCLK = 1'b0;
      RX_DATA = 24'h0;
      RX_CTRL = 3'h0;
      REG_ADDR = 4'h0;
      REG_WDATA = 8'h0;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      straps = 24'h0;
      hold_strap = 1'b0;
      n_mismatch = 0;
      cmp_count = 0;
      cyc(2);
      RESETN <= 1'b1;
      LOCK_IN <= 1'b1;
      // powered down since reset: pins released, map at default
      cyc(4);
      `CHK({DO_OE, CO_OE, PIXEL_CLK_OE}, 26'h0)
      `CHK(MAP_SEL, 2'h0)
      // every filter code, spread off once, sleep select both ways
      for (int m = 0; m < 4; m++) begin
         s = pat[m];
         s[PIN_MODE1] = m[1];
         s[PIN_MODE0] = m[0];
         s[PIN_LOW_BAND] = 1'b1;
         s[PIN_SLEEP_SEL] = m[0];
         if (m == 2) s[PIN_SPREAD_LSB +: 4] = SPREAD_OFF;
         straps <= s;
         pwr(1'b1);
         chk_opts(s);
         `CHK({DO_OE, LOCK_OUT}, {24'hffffff, 1'b1})
         pwr(1'b0);
         `CHK(LOCK_OUT, 1'b0)
         `CHK({DO_OE, DO_OUT}, {{24{s[PIN_SLEEP_SEL]}}, 24'h0})
      end
      // launch edge for each strobe setting, chosen by register
      s = 24'h0;
      s[PIN_STROBE] = 1'b1;
      straps <= s;
      pwr(1'b1);
      xp = 27'h0;
      for (int e = 1; e >= 0; e--) begin
         wr(REG_CFG0, {e[0], 7'h0});
         for (int k = 0; k < 2; k++) begin
            {RX_DATA, RX_CTRL} <= 27'h2d3c5a9 + 27'(k * 5 + e);
            pk(!RX_PCLK);
            if (RX_PCLK == !e[0]) xp = {RX_DATA, RX_CTRL};
            `CHK({DO_OUT, CO_OUT}, xp)
         end
      end
      // lock lost: sleep select drives pins low
      wr(REG_CFG0, 8'h40);
      LOCK_IN <= 1'b0;
      cyc(4);
      `CHK({DO_OE, DO_OUT}, {24'hffffff, 24'h0})
      LOCK_IN <= 1'b1;
      // overrides, readback and an unmapped place
      wr(REG_CFG2, 8'h29);
      rd(REG_CFG2);
      `CHK(rd_v, 8'h29)
      `CHK({SPREAD_RANGE, MAP_SEL}, {4'h9, 2'h2})
      wr(REG_CFG1, 8'h3a);
      wr(REG_CFG0, 8'h1c);
      cyc(2);
      `CHK({EQ_LEVEL, OSC_SEL}, {4'ha, 3'h3})
      `CHK({SSC_LOW_BAND, CLK_FAST_SLEW, DATA_FAST_SLEW}, 3'h7)
      wr(REG_CFG2, 8'h00);
      cyc(2);
      `CHK(SSC_LOW_BAND, 1'b0)
      wr(4'hf, 8'hff);
      rd(4'hf);
      `CHK(rd_v, 8'h00)
      // hold-low strap alone: outputs low until released
      pwr(1'b0);
      straps <= 24'h0;
      hold_strap <= 1'b1;
      {RX_DATA, RX_CTRL} <= 27'h5a5a5a5;
      pwr(1'b1);
      pk(1'b1);
      pk(1'b0);
      `CHK({DO_OE, DO_OUT}, {24'hffffff, 24'h0})
      rd(REG_STATUS);
      `CHK(rd_v[STAT_HOLDING], 1'b1)
      wr(REG_CTRL, 8'h01);
      pk(1'b1);
      pk(1'b0);
      `CHK({DO_OUT, CO_OUT}, {RX_DATA, RX_CTRL})
      `CHK({PIXEL_CLK_OUT, PASS_OUT}, {RX_PCLK, BIST_PASS_IN})
      complete_run();
   end
endmodule
